// ### src/abcc_audio_bridge_clock_config.v
`timescale 1ns/1ps
`default_nettype none
`include "abcc_map.vh"
module abcc_audio_bridge_clock_config (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_mode_select_strap_0,
  input wire [`ABCC_ADDR_W-1:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  output reg o_tdm_fanout_en,
  output reg o_swc_falling_edge,
  output reg o_audio_split_active,
  output reg o_audio_both_ports,
  output reg o_sbs_3d_convert,
  output reg o_dual_input_lr,
  output reg o_cont_clk_fault,
  output reg [2:0] o_tx_clk_sel_p0,
  output reg [2:0] o_tx_clk_sel_p1
);

  reg [7:0] audio_config_r;
  reg [7:0] bridge_config_two_r;
  reg [7:0] bridge_control_r;
  reg [7:0] tx_mode_r;
  reg [1:0] clk_mode_p1_r;
  reg strap_done_r;
  reg ack_r;
  reg [7:0] audio_config_nxt;
  reg [7:0] bridge_config_two_nxt;
  reg [7:0] bridge_control_nxt;
  reg [7:0] tx_mode_nxt;
  reg [1:0] clk_mode_p1_nxt;
  reg [7:0] rdata_nxt;
  wire req;
  wire wr_go;
  wire [7:0] idx;
  wire [7:0] wbyte;
  wire [7:0] b2_masked;
  wire hit_audio;
  wire hit_b2;
  wire hit_ctl;
  wire hit_txm;
  wire is_repl;
  wire is_indep;
  wire sel_port1;
  wire split_on;
  wire dual_lr_on;
  wire cont_clk_fault;
  wire [1:0] port_mode [0:1];
  wire [2:0] port_sel [0:1];

  function reg_hit;
    input [7:0] index;
    input [7:0] target;
    begin
      reg_hit = (index == target);
    end
  endfunction

  function [2:0] clk_src;
    input [1:0] mode;
    input port1;
    input indep;
    begin
      case (mode)
        `ABCC_CLK_DSI: clk_src = `ABCC_SRC_DSI;
        `ABCC_CLK_EXT: clk_src = `ABCC_SRC_REF;
        `ABCC_CLK_INT: clk_src = `ABCC_SRC_INT;
        `ABCC_CLK_EXT2:
        begin
          // outside independent 2:2 the code falls back to the single reference pin
          if (indep)
            clk_src = port1 ? `ABCC_SRC_REF1 : `ABCC_SRC_REF0;
          else
            clk_src = `ABCC_SRC_REF;
        end
        default: clk_src = `ABCC_SRC_DSI;
      endcase
    end
  endfunction

  // address index is address divided by four; unaligned low bits ignored
  assign idx = i_avs_address[9:2];
  assign wbyte = i_avs_writedata[7:0];
  assign req = (i_avs_read | i_avs_write) & ~ack_r;
  // a write lands only on the edge after waitrequest drops, the one where the master samples it low
  assign wr_go = i_avs_write & ack_r & i_avs_byteenable[0];
  assign b2_masked = wbyte & `ABCC_B2_WMASK;
  assign hit_audio = reg_hit(idx, `ABCC_IDX_AUDIO_CONFIG);
  assign hit_b2 = reg_hit(idx, `ABCC_IDX_BRIDGE_CONFIG_TWO);
  assign hit_ctl = reg_hit(idx, `ABCC_IDX_BRIDGE_CONTROL);
  assign hit_txm = reg_hit(idx, `ABCC_IDX_TX_MODE);
  assign is_repl = (tx_mode_r[1:0] == `ABCC_TXM_REPLICATE) | (tx_mode_r[1:0] == `ABCC_TXM_SPLITTER);
  assign is_indep = tx_mode_r[`ABCC_TXM_INDEP_BIT];
  assign sel_port1 = tx_mode_r[`ABCC_TXM_PORT_BIT];
  assign split_on = is_repl & audio_config_r[`ABCC_AUD_SPLIT];
  assign dual_lr_on = bridge_config_two_r[`ABCC_B2_DUAL_LR] & bridge_control_r[`ABCC_CTL_DUAL_IN];
  assign cont_clk_fault = (bridge_config_two_r[1:0] == `ABCC_CLK_DSI) & ~bridge_control_r[`ABCC_CTL_CONT_CLK];
  assign port_mode[0] = bridge_config_two_r[1:0];
  // port 1 shares the field unless the ports run independently
  assign port_mode[1] = is_indep ? clk_mode_p1_r : bridge_config_two_r[1:0];

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : g_port_clk
      assign port_sel[p] = clk_src(port_mode[p], p == 1, is_indep);
    end
  endgenerate

  always @*
  begin
    rdata_nxt = 8'h00;
    if (hit_audio)
      rdata_nxt = audio_config_r;
    else if (hit_b2)
      rdata_nxt = bridge_config_two_r;
    else if (hit_ctl)
      rdata_nxt = bridge_control_r;
    else if (hit_txm)
      rdata_nxt = tx_mode_r;
    else
      rdata_nxt = 8'h00;
  end

  // one wait cycle: waitrequest drops on the cycle after the request appears
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      ack_r <= 1'b0;
      o_avs_waitrequest <= 1'b1;
    end
    else
    begin
      ack_r <= req;
      o_avs_waitrequest <= ~req;
    end
  end

  // read data is captured early so it already stands when waitrequest is low
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_avs_readdata <= 32'h00000000;
    end
    else if (req & i_avs_read)
    begin
      o_avs_readdata <= {24'h000000, rdata_nxt};
    end
  end

  always @*
  begin
    audio_config_nxt = audio_config_r;
    if (~strap_done_r)
    begin
      // no write can complete on the first edge after reset, so the strap never races one
      audio_config_nxt[`ABCC_AUD_SPLIT] = i_mode_select_strap_0;
    end
    else if (wr_go & hit_audio)
    begin
      audio_config_nxt = wbyte & `ABCC_AUD_WMASK;
    end
  end

  always @*
  begin
    bridge_config_two_nxt = bridge_config_two_r;
    clk_mode_p1_nxt = clk_mode_p1_r;
    if (wr_go & hit_b2)
    begin
      bridge_config_two_nxt[7:2] = b2_masked[7:2];
      // in independent 2:2 the field lands on the selected port
      if (is_indep & sel_port1)
      begin
        clk_mode_p1_nxt = b2_masked[1:0];
      end
      else
      begin
        bridge_config_two_nxt[1:0] = b2_masked[1:0];
      end
    end
  end

  always @*
  begin
    bridge_control_nxt = bridge_control_r;
    if (wr_go & hit_ctl)
    begin
      bridge_control_nxt = wbyte & `ABCC_CTL_WMASK;
    end
  end

  always @*
  begin
    tx_mode_nxt = tx_mode_r;
    if (wr_go & hit_txm)
    begin
      tx_mode_nxt = wbyte & `ABCC_TXM_WMASK;
    end
  end

  // strap is sampled on the first clock after reset release, never under reset
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      audio_config_r <= `ABCC_AUD_RESET;
      bridge_config_two_r <= `ABCC_B2_RESET;
      bridge_control_r <= `ABCC_CTL_RESET;
      tx_mode_r <= `ABCC_TXM_RESET;
      clk_mode_p1_r <= `ABCC_P1_MODE_RESET;
      strap_done_r <= 1'b0;
    end
    else
    begin
      audio_config_r <= audio_config_nxt;
      bridge_config_two_r <= bridge_config_two_nxt;
      bridge_control_r <= bridge_control_nxt;
      tx_mode_r <= tx_mode_nxt;
      clk_mode_p1_r <= clk_mode_p1_nxt;
      strap_done_r <= 1'b1;
    end
  end

  // audio controls; the converters downstream follow these levels
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_tdm_fanout_en <= 1'b0;
      o_swc_falling_edge <= 1'b0;
      o_audio_split_active <= 1'b0;
      o_audio_both_ports <= 1'b1;
    end
    else
    begin
      o_tdm_fanout_en <= audio_config_r[`ABCC_AUD_TDM_FANOUT];
      o_swc_falling_edge <= audio_config_r[`ABCC_AUD_WCLK_EDGE];
      o_audio_split_active <= split_on;
      o_audio_both_ports <= ~split_on;
    end
  end

  // video controls; the line buffers follow these levels
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_sbs_3d_convert <= 1'b0;
      o_dual_input_lr <= 1'b0;
    end
    else
    begin
      o_sbs_3d_convert <= bridge_config_two_r[`ABCC_B2_SBS_3D];
      // merge only runs once dual input is also enabled
      o_dual_input_lr <= dual_lr_on;
    end
  end

  // clock controls; a fault flag rather than a refusal lets software set up in any order
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_cont_clk_fault <= 1'b0;
      o_tx_clk_sel_p0 <= `ABCC_SRC_DSI;
      o_tx_clk_sel_p1 <= `ABCC_SRC_DSI;
    end
    else
    begin
      o_cont_clk_fault <= cont_clk_fault;
      // the clock muxes switch one cycle after the field changes
      o_tx_clk_sel_p0 <= port_sel[0];
      o_tx_clk_sel_p1 <= port_sel[1];
    end
  end

endmodule // abcc_audio_bridge_clock_config
`default_nettype wire

// ### src/abcc_map.vh
`ifndef ABCC_MAP_VH
`define ABCC_MAP_VH
// register index; the byte address is four times the index
`define ABCC_IDX_AUDIO_CONFIG 8'h55
`define ABCC_IDX_BRIDGE_CONFIG_TWO 8'h56
`define ABCC_IDX_BRIDGE_CONTROL 8'h5A
`define ABCC_IDX_TX_MODE 8'h5B
`define ABCC_ADDR_W 10
// audio_config fields
`define ABCC_AUD_TDM_FANOUT 7
`define ABCC_AUD_WCLK_EDGE 5
`define ABCC_AUD_SPLIT 4
`define ABCC_AUD_WMASK 8'hB0
`define ABCC_AUD_RESET 8'h00
// bridge_config_two fields
`define ABCC_B2_SBS_3D 7
`define ABCC_B2_DUAL_LR 6
`define ABCC_B2_CLK_HI 1
`define ABCC_B2_CLK_LO 0
`define ABCC_B2_WMASK 8'hC3
`define ABCC_B2_RESET 8'h00
`define ABCC_P1_MODE_RESET 2'h0
// bridge_control fields
`define ABCC_CTL_DUAL_IN 0
`define ABCC_CTL_CONT_CLK 1
`define ABCC_CTL_WMASK 8'h03
`define ABCC_CTL_RESET 8'h00
// transmit mode register: bits 1-0 mode, bit 2 selected port, bit 3 independent 2:2
`define ABCC_TXM_WMASK 8'h0F
`define ABCC_TXM_RESET 8'h00
`define ABCC_TXM_PORT_BIT 2
`define ABCC_TXM_SINGLE 2'h0
`define ABCC_TXM_DUAL 2'h1
`define ABCC_TXM_REPLICATE 2'h2
`define ABCC_TXM_SPLITTER 2'h3
`define ABCC_TXM_INDEP_BIT 3
// clock source codes
`define ABCC_CLK_DSI 2'h0
`define ABCC_CLK_EXT 2'h1
`define ABCC_CLK_INT 2'h2
`define ABCC_CLK_EXT2 2'h3
// clock select outputs: 0 dsi, 1 reference pin, 2 reference pin 0, 3 reference pin 1, 4 internal
`define ABCC_SRC_DSI 3'h0
`define ABCC_SRC_REF 3'h1
`define ABCC_SRC_REF0 3'h2
`define ABCC_SRC_REF1 3'h3
`define ABCC_SRC_INT 3'h4
`endif

// ### dv/abcc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module abcc_chk (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_tdm_fanout_en,
  input wire logic o_audio_split_active,
  input wire logic o_audio_both_ports,
  input wire logic o_sbs_3d_convert
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  wire logic wdone = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  wire logic rdone = i_avs_read && !o_avs_waitrequest;
  wire logic [7:0] idx = i_avs_address[9:2];
  AST_TDM: assert property (wdone && idx == 8'h55 |-> ##2 o_tdm_fanout_en == $past(i_avs_writedata[7], 2))
    else $error("fan-out enable wrong");
  AST_SBS: assert property (wdone && idx == 8'h56 |-> ##2 o_sbs_3d_convert == $past(i_avs_writedata[7], 2))
    else $error("3d convert wrong");
  AST_BOTH: assert property (o_audio_both_ports != o_audio_split_active)
    else $error("port routing wrong");
  AST_RSVD: assert property (rdone && idx == 8'h55 |-> (o_avs_readdata & 32'hFFFFFF4F) == 32'h0)
    else $error("reserved bits set");
  AST_HIGH: assert property (rdone |-> o_avs_readdata[31:8] == 24'h0)
    else $error("upper bits set");
  AST_WAIT: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("no answer");
  AST_ONE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("answer too long");
  AST_IDLE: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
    else $error("answer without request");
  cover property (wdone && idx == 8'h56);
  cover property (o_audio_split_active);
  cover property (rdone && idx == 8'h55);
endmodule // abcc_chk
bind abcc_audio_bridge_clock_config abcc_chk u_chk (.i_clock, .i_sys_rst, .i_avs_address, .i_avs_read,
  .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
  .o_tdm_fanout_en, .o_audio_split_active, .o_audio_both_ports, .o_sbs_3d_convert);
`default_nettype wire

// ### dv/abcc_audio_bridge_clock_config_test.sv
`timescale 1ns/1ps
`default_nettype none
module abcc_audio_bridge_clock_config_test;
  logic clk = 0, rst = 1, rd = 0, wr = 0, wreq, tdm, swc, spl, both, sbs, dlr, ccf;
  logic [9:0] adr = '0;
  logic [31:0] wd = '0, rdat;
  logic [2:0] s0, s1;
  logic strap = 1;
  logic [7:0] q;
  int fails = 0, n_tests = 0;
  always #2 clk = ~clk;
  abcc_audio_bridge_clock_config dut (.i_clock(clk), .i_sys_rst(rst), .i_mode_select_strap_0(strap),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_tdm_fanout_en(tdm),
    .o_swc_falling_edge(swc), .o_audio_split_active(spl), .o_audio_both_ports(both),
    .o_sbs_3d_convert(sbs), .o_dual_input_lr(dlr), .o_cont_clk_fault(ccf), .o_tx_clk_sel_p0(s0),
    .o_tx_clk_sel_p1(s1));
  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // one edge always passes before a new request, so no signal is driven twice in a step
  task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wreq !== 1'b0 && k < 20);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 20)
    begin
      fails++;
      close_out();
    end
  endtask
  task t_strap;
    bus(0, 10'h154, 8'h00);
    chk(q, 8'h10);
    chk({7'h0, both}, 8'h01);
    $display("strap test done");
  endtask
  task t_audio;
    bus(1, 10'h154, 8'hFF);
    bus(0, 10'h154, 8'h00);
    chk(q, 8'hB0);
    chk({5'h0, tdm, swc, spl}, 8'h06);
    bus(1, 10'h16C, 8'h02);
    bus(0, 10'h3FC, 8'h00);
    chk(q, 8'h00);
    chk({6'h0, spl, both}, 8'h02);
    $display("audio test done");
  endtask
  task t_clk;
    logic [2:0] e [4];
    e = '{3'h0, 3'h1, 3'h4, 3'h1};
    // line length and image delay live outside this block; mode is replicate, not splitter
    for (int i = 0; i < 4; i++)
    begin
      bus(1, 10'h158, 8'hC0 | 8'(i));
      bus(0, 10'h158, 8'h00);
      chk(q, 8'hC0 | 8'(i));
      chk({5'h0, s0}, {5'h0, e[i]});
      chk({5'h0, sbs, dlr, ccf}, {6'h1, 1'b0, i == 0});
    end
    bus(1, 10'h168, 8'h01);
    bus(0, 10'h168, 8'h00);
    chk({7'h0, dlr}, 8'h01);
    $display("clock test done");
  endtask
  task t_indep;
    bus(1, 10'h16C, 8'h0C);
    bus(1, 10'h158, 8'hC1);
    bus(1, 10'h16C, 8'h08);
    bus(1, 10'h158, 8'hC3);
    bus(0, 10'h158, 8'h00);
    chk(q, 8'hC3);
    chk({2'h0, s0, s1}, {2'h0, 3'h2, 3'h1});
    $display("independent test done");
  endtask
  task t_reset;
    strap <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(0, 10'h154, 8'h00);
    chk(q, 8'h00);
    chk({6'h0, spl, both}, 8'h01);
    $display("reset test done");
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_strap();
    t_audio();
    t_clk();
    t_indep();
    t_reset();
    close_out();
  end
endmodule // abcc_audio_bridge_clock_config_test
`default_nettype wire
